// ### inc/pes_pkg.sv
// Behaviour
// - A steered request leaves only while its host do-command enable is set.
// - Correctable first pointer sits read-only in 28:24, holds, rearms when all clear; sticky.
// - Simultaneous errors make a pointer record the lowest flagged bit number.
// - Unit first pointer in 20:16 locks on first unit error, rearms when clear; sticky.
// - Unit pointer is meaningful only for errors enabled for reporting.
// - Bit 15 enables header log capture for link layer engine protocol errors.
// - Bit 14 gates all fatal, non-fatal and correctable unit error reporting.
// - Fields 13:12, 11:10, 9:8 steer unit fatal, non-fatal, correctable; 00 is SCI.
// - Fields 5:4, 3:2, 1:0 steer root port fatal, non-fatal, correctable; 00 is SCI.
// - Root port paths act only with root port control bit 2, 1 or 0 set.
// - A masked uncorrectable error is neither logged nor reported.
// - Mask bits 20, 18, 17, 16 suppress their error when set.
// - Mask bits 15, 14, 13, 12, 4 suppress their error when set.
// - Mask bits 19 and 0 are not implemented and read zero.
// - Mask bits are sticky over ordinary reset; power-on clears both registers.
package pes_pkg;

  localparam int ADR_W = 12;
  localparam int IRQ_W = 4;
  localparam int NPATH = 6;

  // register offsets
  localparam logic [ADR_W-1:0] OFS_STEER   = 12'h148;
  localparam logic [ADR_W-1:0] OFS_UMASK   = 12'h14C;
  localparam logic [ADR_W-1:0] OFS_IRQ_STS = 12'h180;
  localparam logic [ADR_W-1:0] OFS_IRQ_MSK = 12'h184;
  localparam logic [ADR_W-1:0] OFS_HOST_EN = 12'h188;
  localparam logic [ADR_W-1:0] OFS_RP_CTL  = 12'h18C;

  // field positions in the steering register
  localparam int CORR_PTR_LSB = 24;
  localparam int UNIT_PTR_LSB = 16;
  localparam int HDR_LOG_BIT  = 15;
  localparam int UNIT_EN_BIT  = 14;

  // writable bits and reset values
  localparam logic [31:0] STEER_CTL_MSK = 32'h0000_FF3F;
  localparam logic [31:0] UMASK_IMPL    = 32'h0017_F010;
  localparam logic [31:0] RST_STEER     = 32'h0000_0000;
  localparam logic [31:0] RST_UMASK     = 32'h0000_0000;
  localparam logic [4:0]  RST_PTR       = 5'h00;
  localparam logic [3:0]  RST_HOST_EN   = 4'h0;
  localparam logic [2:0]  RST_RP_CTL    = 3'h0;
  localparam logic [IRQ_W-1:0] RST_IRQ  = 4'h0;

  // steering codes
  localparam logic [1:0] CODE_SCI  = 2'h0;
  localparam logic [1:0] CODE_SMI  = 2'h1;
  localparam logic [1:0] CODE_SERR = 2'h2;
  localparam logic [1:0] CODE_MCE  = 2'h3;

  // request lines, also host do-command enable bits
  localparam int REQ_SCI  = 0;
  localparam int REQ_SMI  = 1;
  localparam int REQ_MCE  = 2;
  localparam int REQ_SERR = 3;

  // interrupt events
  localparam int EV_CORR_LOCK = 0;
  localparam int EV_UNIT_LOCK = 1;
  localparam int EV_UNC_LOG   = 2;
  localparam int EV_REQ_BLOCK = 3;

  // lowest set bit of a 32-bit vector
  function automatic logic [4:0] lowest_set(input logic [31:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        r = i[4:0];
      end
    end
    return r;
  endfunction

  // byte-lane merge of a write under an access mask
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] sel, input logic [31:0] wm);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}} & wm;
    return (old & ~m) | (wd & m);
  endfunction

endpackage

// ### hw/pes_first_ptr.sv
`timescale 1ns/1ps
`default_nettype none
module pes_first_ptr (
  input  wire logic        clk_i,
  input  wire logic        por_i,
  input  wire logic [31:0] stat_i,
  input  wire logic        arm_en_i,
  input  wire logic        wr_i,
  input  wire logic [4:0]  wr_val_i,
  output logic      [4:0]  ptr_o,
  output logic             locked_o,
  output logic             lock_pulse_o
);
  import pes_pkg::*;

  logic [31:0] prev_q;
  logic [31:0] fresh;
  logic        lock_now;

  // bits that became set this cycle
  assign fresh        = stat_i & ~prev_q;
  assign lock_now     = !locked_o && arm_en_i && (|fresh);
  assign lock_pulse_o = lock_now;

  // previous status, sticky like the pointer
  always_ff @(posedge clk_i) begin
    if (por_i) begin
      prev_q <= '0;
    end else begin
      prev_q <= stat_i;
    end
  end

  // lock on the first error, rearm once everything cleared
  always_ff @(posedge clk_i) begin
    if (por_i) begin
      ptr_o    <= RST_PTR;
      locked_o <= 1'b0;
    end else if (lock_now) begin
      ptr_o    <= lowest_set(fresh);
      locked_o <= 1'b1;
    end else begin
      if (wr_i) begin
        ptr_o <= wr_val_i;
      end
      if (locked_o && stat_i == '0) begin
        locked_o <= 1'b0;
      end
    end
  end

  a_ptr_lowest_bit: assert property (@(posedge clk_i) disable iff (por_i)
    lock_now |=> ptr_o == lowest_set($past(fresh)))
    else $error("first pointer not lowest flagged bit");

  a_ptr_holds_lock: assert property (@(posedge clk_i) disable iff (por_i)
    locked_o && !wr_i && stat_i != '0 |=> locked_o && $stable(ptr_o))
    else $error("locked first pointer moved");

endmodule // pes_first_ptr
`default_nettype wire

// ### hw/pes_steer.sv
`timescale 1ns/1ps
`default_nettype none
module pes_steer (
  input  wire logic       en_i,
  input  wire logic       evt_i,
  input  wire logic [1:0] code_i,
  output logic      [3:0] req_o
);
  import pes_pkg::*;

  // one-hot request for the selected signalling method
  always_comb begin
    req_o = 4'h0;
    if (en_i && evt_i) begin
      unique case (code_i)
        CODE_SCI:  req_o[REQ_SCI]  = 1'b1;
        CODE_SMI:  req_o[REQ_SMI]  = 1'b1;
        CODE_SERR: req_o[REQ_SERR] = 1'b1;
        CODE_MCE:  req_o[REQ_MCE]  = 1'b1;
      endcase
    end
  end

endmodule // pes_steer
`default_nettype wire

// ### hw/pes_top.sv
`timescale 1ns/1ps
`default_nettype none
module pes_top (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      por_i,
  // wishbone slave
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [pes_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic      [31:0]               wb_dat_o,
  output logic                           wb_ack_o,
  // error sources
  input  wire logic [31:0]               corr_status_i,
  input  wire logic [31:0]               unit_status_i,
  input  wire logic [31:0]               unc_err_i,
  input  wire logic                      unit_fatal_i,
  input  wire logic                      unit_nonfatal_i,
  input  wire logic                      unit_corr_i,
  input  wire logic                      rp_fatal_i,
  input  wire logic                      rp_nonfatal_i,
  input  wire logic                      rp_corr_i,
  // results
  output logic      [31:0]               unc_log_o,
  output logic                           hdr_log_lle_o,
  output logic                           unit_ptr_valid_o,
  output logic                           request_sci_signal_o,
  output logic                           request_smi_signal_o,
  output logic                           request_machine_check_o,
  output logic                           request_serr_signal_o,
  output logic                           irq_o
);
  import pes_pkg::*;

  // software-visible state
  logic [15:0]      steer_ctl_q;
  logic [31:0]      umask_q;
  logic [3:0]       host_en_q;
  logic [2:0]       rp_ctl_q;
  logic [IRQ_W-1:0] irq_sts_q;
  logic [IRQ_W-1:0] irq_msk_q;
  logic [IRQ_W-1:0] irq_ev;

  // bus handshake
  logic        take;
  logic        wr_en;
  logic        ack_q;
  logic [31:0] rdata;
  logic [31:0] steer_rd;
  logic [31:0] dat_q;

  // first pointers
  logic [4:0] corr_ptr;
  logic [4:0] unit_ptr;
  logic       corr_locked;
  logic       unit_locked;
  logic       corr_lock_ev;
  logic       unit_lock_ev;
  logic       unit_ptr_wr;

  // steering
  logic [NPATH-1:0] path_en;
  logic [NPATH-1:0] path_evt;
  logic [1:0]       path_code [NPATH];
  logic [3:0]       path_req  [NPATH];
  logic [3:0]       req_any;
  logic [3:0]       req_q;
  logic [31:0]      unc_log_d;
  logic [31:0]      steer_wr;

  // request is taken once, acked next cycle
  assign take  = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr_en = take && wb_we_i;

  // steering register image
  assign steer_rd = {3'h0, corr_ptr, 3'h0, unit_ptr, steer_ctl_q[15:8], 2'h0,
                     steer_ctl_q[5:0]};

  // read mux, unmapped offsets read zero
  always_comb begin
    rdata = 32'h0000_0000;
    unique case (wb_adr_i)
      OFS_STEER:   rdata = steer_rd;
      OFS_UMASK:   rdata = umask_q & UMASK_IMPL;
      OFS_IRQ_STS: rdata = {28'h0000000, irq_sts_q};
      OFS_IRQ_MSK: rdata = {28'h0000000, irq_msk_q};
      OFS_HOST_EN: rdata = {28'h0000000, host_en_q};
      OFS_RP_CTL:  rdata = {29'h00000000, rp_ctl_q};
      default:     rdata = 32'h0000_0000;
    endcase
  end

  // ack and read data
  always_ff @(posedge clk_i) begin
    if (rst_i || por_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= take;
      if (take) begin
        dat_q <= rdata;
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // lane-merged write image; only the control half is stored here
  assign steer_wr = merge({16'h0000, steer_ctl_q}, wb_dat_i, wb_sel_i, STEER_CTL_MSK);

  // steering control bits: cleared by any reset
  always_ff @(posedge clk_i) begin
    if (rst_i || por_i) begin
      steer_ctl_q <= RST_STEER[15:0];
    end else if (wr_en && wb_adr_i == OFS_STEER) begin
      steer_ctl_q <= steer_wr[15:0];
    end
  end

  // detect masks survive ordinary reset
  always_ff @(posedge clk_i) begin
    if (por_i) begin
      umask_q <= RST_UMASK;
    end else if (wr_en && wb_adr_i == OFS_UMASK) begin
      umask_q <= merge(umask_q, wb_dat_i, wb_sel_i, UMASK_IMPL);
    end
  end

  // host do-command enables and root port control
  always_ff @(posedge clk_i) begin
    if (rst_i || por_i) begin
      host_en_q <= RST_HOST_EN;
      rp_ctl_q  <= RST_RP_CTL;
    end else if (wr_en && wb_sel_i[0]) begin
      if (wb_adr_i == OFS_HOST_EN) begin
        host_en_q <= wb_dat_i[3:0];
      end
      if (wb_adr_i == OFS_RP_CTL) begin
        rp_ctl_q <= wb_dat_i[2:0];
      end
    end
  end

  // unit pointer takes software writes through byte lane 2
  assign unit_ptr_wr = wr_en && wb_adr_i == OFS_STEER && wb_sel_i[2];

  // correctable first pointer, read only
  pes_first_ptr u_corr_ptr (
    .clk_i        (clk_i),
    .por_i        (por_i),
    .stat_i       (corr_status_i),
    .arm_en_i     (1'b1),
    .wr_i         (1'b0),
    .wr_val_i     (5'h00),
    .ptr_o        (corr_ptr),
    .locked_o     (corr_locked),
    .lock_pulse_o (corr_lock_ev)
  );

  // unit first pointer, locks only while unit reporting is on
  pes_first_ptr u_unit_ptr (
    .clk_i        (clk_i),
    .por_i        (por_i),
    .stat_i       (unit_status_i),
    .arm_en_i     (steer_ctl_q[UNIT_EN_BIT]),
    .wr_i         (unit_ptr_wr),
    .wr_val_i     (wb_dat_i[UNIT_PTR_LSB +: 5]),
    .ptr_o        (unit_ptr),
    .locked_o     (unit_locked),
    .lock_pulse_o (unit_lock_ev)
  );

  assign unit_ptr_valid_o = unit_locked && steer_ctl_q[UNIT_EN_BIT];
  assign hdr_log_lle_o    = steer_ctl_q[HDR_LOG_BIT];

  // path enables: unit paths by bit 14, root paths by control bits
  assign path_en  = {rp_ctl_q[0], rp_ctl_q[1], rp_ctl_q[2],
                     {3{steer_ctl_q[UNIT_EN_BIT]}}};
  assign path_evt = {rp_corr_i, rp_nonfatal_i, rp_fatal_i,
                     unit_corr_i, unit_nonfatal_i, unit_fatal_i};

  // field per path: unit 13:12, 11:10, 9:8 then root 5:4, 3:2, 1:0
  assign path_code[0] = steer_ctl_q[13:12];
  assign path_code[1] = steer_ctl_q[11:10];
  assign path_code[2] = steer_ctl_q[9:8];
  assign path_code[3] = steer_ctl_q[5:4];
  assign path_code[4] = steer_ctl_q[3:2];
  assign path_code[5] = steer_ctl_q[1:0];

  // one decoder per path
  for (genvar p = 0; p < NPATH; p++) begin : g_path
    pes_steer u_steer (
      .en_i   (path_en[p]),
      .evt_i  (path_evt[p]),
      .code_i (path_code[p]),
      .req_o  (path_req[p])
    );
  end

  // merge all paths
  always_comb begin
    req_any = 4'h0;
    for (int p = 0; p < NPATH; p++) begin
      req_any = req_any | path_req[p];
    end
  end

  // requests leave only when the host enable allows them
  always_ff @(posedge clk_i) begin
    if (rst_i || por_i) begin
      req_q <= 4'h0;
    end else begin
      req_q <= req_any & host_en_q;
    end
  end

  assign request_sci_signal_o    = req_q[REQ_SCI];
  assign request_smi_signal_o    = req_q[REQ_SMI];
  assign request_machine_check_o = req_q[REQ_MCE];
  assign request_serr_signal_o   = req_q[REQ_SERR];

  // masked uncorrectable errors are dropped before logging
  assign unc_log_d = unc_err_i & ~umask_q & UMASK_IMPL;

  always_ff @(posedge clk_i) begin
    if (rst_i || por_i) begin
      unc_log_o <= 32'h0000_0000;
    end else begin
      unc_log_o <= unc_log_d;
    end
  end

  // interrupt events
  always_comb begin
    irq_ev               = '0;
    irq_ev[EV_CORR_LOCK] = corr_lock_ev;
    irq_ev[EV_UNIT_LOCK] = unit_lock_ev;
    irq_ev[EV_UNC_LOG]   = |unc_log_d;
    irq_ev[EV_REQ_BLOCK] = |(req_any & ~host_en_q);
  end

  // sticky status, write one to clear, a new event wins
  always_ff @(posedge clk_i) begin
    if (rst_i || por_i) begin
      irq_sts_q <= RST_IRQ;
    end else if (wr_en && wb_adr_i == OFS_IRQ_STS && wb_sel_i[0]) begin
      irq_sts_q <= (irq_sts_q & ~wb_dat_i[IRQ_W-1:0]) | irq_ev;
    end else begin
      irq_sts_q <= irq_sts_q | irq_ev;
    end
  end

  // interrupt mask
  always_ff @(posedge clk_i) begin
    if (rst_i || por_i) begin
      irq_msk_q <= RST_IRQ;
    end else if (wr_en && wb_adr_i == OFS_IRQ_MSK && wb_sel_i[0]) begin
      irq_msk_q <= wb_dat_i[IRQ_W-1:0];
    end
  end

  assign irq_o = |(irq_sts_q & irq_msk_q);

  // checks
  a_req_host_gate: assert property (@(posedge clk_i) disable iff (rst_i || por_i)
    (req_q & ~$past(host_en_q)) == 4'h0)
    else $error("request left without host enable");

  a_unit_rpt_gate: assert property (@(posedge clk_i) disable iff (rst_i || por_i)
    !steer_ctl_q[UNIT_EN_BIT] |-> (path_req[0] | path_req[1] | path_req[2]) == 4'h0)
    else $error("unit request while unit reporting off");

  a_rp_fatal_gate: assert property (@(posedge clk_i) disable iff (rst_i || por_i)
    !rp_ctl_q[2] |-> path_req[3] == 4'h0)
    else $error("root fatal request while disabled");

  a_sci_code_path: assert property (@(posedge clk_i) disable iff (rst_i || por_i)
    rp_corr_i && rp_ctl_q[0] && steer_ctl_q[1:0] == CODE_SCI && host_en_q[REQ_SCI]
    |=> request_sci_signal_o)
    else $error("correctable root error missed SCI");

  a_unit_fat_code: assert property (@(posedge clk_i) disable iff (rst_i || por_i)
    unit_fatal_i && steer_ctl_q[UNIT_EN_BIT] && steer_ctl_q[13:12] == CODE_SCI
    |-> path_req[0][REQ_SCI])
    else $error("unit fatal not steered to SCI");

  a_unc_masked_out: assert property (@(posedge clk_i) disable iff (rst_i || por_i)
    (unc_log_o & $past(umask_q)) == 32'h0000_0000)
    else $error("masked uncorrectable error logged");

  a_mask_ro_zero: assert property (@(posedge clk_i) disable iff (rst_i || por_i)
    ack_q && $past(wb_adr_i) == OFS_UMASK |-> wb_dat_o[19] == 1'b0 && wb_dat_o[0] == 1'b0)
    else $error("unimplemented mask bit read one");

  a_mask_sticky_rst: assert property (@(posedge clk_i) disable iff (por_i)
    rst_i |=> $stable(umask_q))
    else $error("mask lost over ordinary reset");

  a_wb_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i || por_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");

  a_hdr_log_bit: assert property (@(posedge clk_i) disable iff (rst_i || por_i)
    wr_en && wb_adr_i == OFS_STEER && wb_sel_i[1] |=> hdr_log_lle_o == $past(wb_dat_i[15]))
    else $error("header log enable not written");

  // a taken request is answered in the very next cycle
  a_wb_ack_next: assert property (@(posedge clk_i) disable iff (rst_i || por_i)
    take |=> wb_ack_o)
    else $error("ack missing after taken request");

  a_rp_nf_gate: assert property (@(posedge clk_i) disable iff (rst_i || por_i)
    !rp_ctl_q[1] |-> path_req[4] == 4'h0)
    else $error("root non-fatal request while disabled");

  a_rp_corr_gate: assert property (@(posedge clk_i) disable iff (rst_i || por_i)
    !rp_ctl_q[0] |-> path_req[5] == 4'h0)
    else $error("root correctable request while disabled");

  a_unit_valid_gate: assert property (@(posedge clk_i) disable iff (rst_i || por_i)
    !steer_ctl_q[UNIT_EN_BIT] |-> !unit_ptr_valid_o)
    else $error("unit pointer valid while reporting off");

  // software writes never move the read-only correctable pointer
  a_corr_ptr_ro: assert property (@(posedge clk_i) disable iff (por_i)
    wr_en && wb_adr_i == OFS_STEER && !corr_lock_ev |=> $stable(corr_ptr))
    else $error("correctable pointer moved by a write");

  a_steer_rsvd_zero: assert property (@(posedge clk_i) disable iff (rst_i || por_i)
    ack_q && $past(wb_adr_i) == OFS_STEER |-> (wb_dat_o & 32'hE0E0_00C0) == 32'h0000_0000)
    else $error("reserved steering bit read one");

  a_unc_unmasked_log: assert property (@(posedge clk_i) disable iff (rst_i || por_i)
    (unc_err_i & ~umask_q & UMASK_IMPL) != 32'h0000_0000 |=> unc_log_o != 32'h0000_0000)
    else $error("unmasked uncorrectable error not logged");

  // a new event beats a write-one clear in the same cycle
  a_irq_set_wins: assert property (@(posedge clk_i) disable iff (rst_i || por_i)
    irq_ev != '0 |=> ($past(irq_ev) & ~irq_sts_q) == '0)
    else $error("interrupt event lost to a clear");

endmodule // pes_top
`default_nettype wire

// ### bench/pes_err_src.sv
`timescale 1ns/1ps
`default_nettype none
// far side model: error sources of the root port hierarchy and of the unit
module pes_err_src (
  input  wire logic        clk_i,
  output logic      [31:0] corr_status_o,
  output logic      [31:0] unit_status_o,
  output logic      [31:0] unc_err_o,
  output logic      [5:0]  cls_o
);
  // quiet sources at time zero
  initial begin
    corr_status_o = 32'h0000_0000;
    unit_status_o = 32'h0000_0000;
    unc_err_o     = 32'h0000_0000;
    cls_o         = 6'h00;
  end

  // one-cycle event pulses: rp corr, nf, fatal, unit corr, nf, fatal
  task automatic pulse(input logic [5:0] cls, input logic [31:0] unc);
    @(posedge clk_i);
    cls_o     <= cls;
    unc_err_o <= unc;
    @(posedge clk_i);
    cls_o     <= 6'h00;
    unc_err_o <= 32'h0000_0000;
  endtask

  // pending status levels, held until changed again
  task automatic levels(input logic [31:0] c, input logic [31:0] u);
    @(posedge clk_i);
    corr_status_o <= c;
    unit_status_o <= u;
  endtask
endmodule // pes_err_src
`default_nettype wire

// ### bench/pes_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module pes_top_test;
  import pes_pkg::*;
  logic        clk_i = 1'b0, rst_i = 1'b1, por_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [31:0] dat = 32'h0000_0000, q, unc_log, corr_s, unit_s, unc_e;
  logic [31:0] wb_dat_o;
  logic [5:0]  cls;
  logic [3:0]  sel = 4'hF, lanes = 4'hF;
  logic        wb_ack_o, hdr_o, uvalid_o, irq_o;
  logic [3:0]  req;
  int          failures = 0, n_tests = 0;

  always #4 clk_i = ~clk_i;

  pes_err_src pes_err_src_i (.clk_i(clk_i), .corr_status_o(corr_s), .unit_status_o(unit_s),
    .unc_err_o(unc_e), .cls_o(cls));

  pes_top pes_top_i (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .corr_status_i(corr_s),
    .unit_status_i(unit_s), .unc_err_i(unc_e), .unit_fatal_i(cls[5]),
    .unit_nonfatal_i(cls[4]), .unit_corr_i(cls[3]), .rp_fatal_i(cls[2]),
    .rp_nonfatal_i(cls[1]), .rp_corr_i(cls[0]), .unc_log_o(unc_log),
    .hdr_log_lle_o(hdr_o), .unit_ptr_valid_o(uvalid_o),
    .request_sci_signal_o(req[REQ_SCI]), .request_smi_signal_o(req[REQ_SMI]),
    .request_machine_check_o(req[REQ_MCE]), .request_serr_signal_o(req[REQ_SERR]),
    .irq_o(irq_o));

  // verdict and end of run
  task automatic results();
    if (failures == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // classic wishbone cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= lanes;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask

  // request vector expected for one steering code
  function automatic logic [3:0] code_req(input int c);
    logic [3:0] r;
    r = 4'h0;
    case (c)
      0: r[REQ_SCI] = 1'b1;
      1: r[REQ_SMI] = 1'b1;
      2: r[REQ_SERR] = 1'b1;
      default: r[REQ_MCE] = 1'b1;
    endcase
    return r;
  endfunction

  initial begin
    #100000;
    failures++;
    results();
  end

  // main sequence
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0; por_i <= 1'b0;
    wb(0, OFS_STEER, 0); chk(q, 32'h0000_0000);
    wb(0, OFS_UMASK, 0); chk(q, 32'h0000_0000);
    wb(0, 12'h000, 0); chk(q, 32'h0000_0000);
    // access kinds, reserved and unimplemented bits
    wb(1, OFS_UMASK, 32'hFFFF_FFFF); wb(0, OFS_UMASK, 0);
    chk(q, 32'h0017_F010);
    wb(1, OFS_STEER, 32'hFFFF_FFFF); wb(0, OFS_STEER, 0);
    chk(q, 32'h001F_FF3F);
    chk({31'h0, hdr_o}, 32'h1);
    // ordinary reset keeps sticky state, power-on clears it
    @(posedge clk_i); rst_i <= 1'b1; @(posedge clk_i); rst_i <= 1'b0;
    wb(0, OFS_UMASK, 0); chk(q, 32'h0017_F010);
    wb(0, OFS_STEER, 0); chk(q, 32'h001F_0000);
    @(posedge clk_i); por_i <= 1'b1; @(posedge clk_i); por_i <= 1'b0;
    wb(0, OFS_UMASK, 0); chk(q, 32'h0000_0000);
    wb(0, OFS_STEER, 0); chk(q, 32'h0000_0000);
    // detect mask suppresses logging
    wb(1, OFS_UMASK, 32'h0001_0000);
    pes_err_src_i.pulse(6'h00, 32'h0001_1010); #1;
    chk(unc_log, 32'h0000_1010);
    wb(1, OFS_UMASK, 32'h0017_F010);
    pes_err_src_i.pulse(6'h00, 32'h0017_F010); #1;
    chk(unc_log, 32'h0000_0000);
    // every steering code on every root port and unit path
    wb(1, OFS_HOST_EN, 32'hF); wb(1, OFS_RP_CTL, 32'h7);
    for (int p = 0; p < 3; p++) begin
      for (int c = 0; c < 4; c++) begin
        wb(1, OFS_STEER, c << (2 * p));
        pes_err_src_i.pulse(6'h01 << p, 0); #1;
        chk({28'h0, req}, {28'h0, code_req(c)});
        wb(1, OFS_STEER, 32'h4000 | (c << (8 + 2 * p)));
        pes_err_src_i.pulse(6'h08 << p, 0); #1;
        chk({28'h0, req}, {28'h0, code_req(c)});
      end
    end
    wb(1, OFS_STEER, 0); pes_err_src_i.pulse(6'h38, 0); #1;
    chk({28'h0, req}, 32'h0);
    wb(1, OFS_RP_CTL, 32'h0); pes_err_src_i.pulse(6'h07, 0); #1;
    chk({28'h0, req}, 32'h0);
    // host enable off blocks the request and raises the interrupt
    wb(1, OFS_RP_CTL, 32'h7); wb(1, OFS_HOST_EN, 32'hE);
    wb(1, OFS_IRQ_MSK, 32'h8); wb(1, OFS_IRQ_STS, 32'hF);
    pes_err_src_i.pulse(6'h01, 0); #1;
    chk({28'h0, req}, 32'h0);
    wb(0, OFS_IRQ_STS, 0); chk(q & 32'h8, 32'h8);
    chk({31'h0, irq_o}, 32'h1);
    wb(1, OFS_IRQ_MSK, 32'h0); chk({31'h0, irq_o}, 32'h0);
    wb(1, OFS_IRQ_MSK, 32'h8); wb(1, OFS_IRQ_STS, 32'h8);
    chk({31'h0, irq_o}, 32'h0);
    // first error pointers
    pes_err_src_i.levels(32'h0000_0220, 0); repeat (2) @(posedge clk_i);
    wb(0, OFS_STEER, 0); chk({27'h0, q[28:24]}, 32'h5);
    pes_err_src_i.levels(32'h0000_0228, 0); repeat (2) @(posedge clk_i);
    wb(0, OFS_STEER, 0); chk({27'h0, q[28:24]}, 32'h5);
    pes_err_src_i.levels(0, 0); repeat (2) @(posedge clk_i);
    pes_err_src_i.levels(32'h0000_0080, 0); repeat (2) @(posedge clk_i);
    wb(0, OFS_STEER, 0); chk({27'h0, q[28:24]}, 32'h7);
    wb(1, OFS_STEER, 32'h4000);
    pes_err_src_i.levels(0, 32'h0000_0300); repeat (2) @(posedge clk_i);
    wb(0, OFS_STEER, 0); chk({27'h0, q[20:16]}, 32'h8);
    chk({31'h0, uvalid_o}, 32'h1);
    wb(1, OFS_STEER, 32'h0); chk({31'h0, uvalid_o}, 32'h0);
    chk({31'h0, hdr_o}, 32'h0);
    // byte lanes: only lane 0 written, upper control byte and unit pointer untouched
    lanes = 4'h1; wb(1, OFS_STEER, 32'hFFFF_FFFF); lanes = 4'hF;
    wb(0, OFS_STEER, 0); chk(q & 32'h001F_FFFF, 32'h0000_003F);
    results();
  end
endmodule // pes_top_test
`default_nettype wire
